// *** logic/tdc_pkg.sv ***
// Constants, register map and state type of the two-channel transfer controller
// What this block does
// - Two channels, each with its own request input and acknowledge output.
// - Unit is byte, word, longword or sixteen bytes as four longword accesses: four reads then four writes in dual-address mode.
// - Up to 16,777,216 units in one programmed run; 4,194,304 for sixteen-byte units.
// - Source and destination addresses are full 32-bit values.
// - Single-address: one side by acknowledge, other by address, one bus cycle per unit, four for sixteen-byte units.
// - Dual-address: both sides by address, a read then a write per unit.
// - Requests come from the pin, the serial module or auto-request.
// - Pin requests use edge or level detection, active low or high.
// - Cycle-steal and burst bus modes are selectable.
// - Channel arbitration is fixed priority or round-robin.
// - A channel raises an interrupt request when its run ends.
// - Controller, bus controller and break controller areas are refused when a unit starts from idle; burst follow-on units are not checked.
// - Processor keeps running from cache; only the external bus is shared.
// - Control bit 1 clears only by writing 0 after reading 1.
// - Operation bits 1 and 2 clear only by writing 0 after reading 1.
// - Count uses 24 bits, upper bits read zero, zero means maximum.
// - Sixteen-byte units always advance the source by sixteen.
package tdc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [1:0][31:0] IX_SA  = {32'hFFFFFF90, 32'hFFFFFF80};
  localparam logic [1:0][31:0] IX_DA  = {32'hFFFFFF94, 32'hFFFFFF84};
  localparam logic [1:0][31:0] IX_CNT = {32'h0FFFFF98, 32'h0FFFFF88};
  localparam logic [1:0][31:0] IX_CC  = {32'h0FFFFF9C, 32'h0FFFFF8C};
  localparam logic [1:0][31:0] IX_VEC = {32'hFFFFFFA8, 32'hFFFFFFA0};
  localparam logic [1:0][31:0] IX_RS  = {32'hFFFFFE72, 32'hFFFFFE71};
  localparam logic [31:0]      IX_OP  = 32'h0FFFFFB0;
  // Channel control fields
  localparam int CC_DE = 0;
  localparam int CC_TE = 1;
  localparam int CC_IE = 2;
  localparam int CC_TA = 3;
  localparam int CC_TB = 4;
  localparam int CC_DL = 5;
  localparam int CC_DS = 6;
  localparam int CC_AL = 7;
  localparam int CC_AM = 8;
  localparam int CC_AR = 9;
  localparam int CC_TS = 10;
  localparam int CC_SM = 12;
  localparam int CC_DM = 14;
  // Shared operation and request select fields
  localparam int OP_DME  = 0;
  localparam int OP_NMIF = 1;
  localparam int OP_AE   = 2;
  localparam int OP_PR   = 3;
  localparam int RS_SER  = 0;
  // Reset values
  localparam logic [15:0] CC_RST = 16'h0000;
  localparam logic [3:0]  OP_RST = 4'h0;
  localparam logic [7:0]  RS_RST = 8'h00;
  // Encodings
  localparam logic [1:0]  TS_LONG  = 2'h2;
  localparam logic [1:0]  TS_16    = 2'h3;
  localparam logic [1:0]  AM_INC   = 2'h1;
  localparam logic [1:0]  AM_DEC   = 2'h2;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  // Forbidden on-chip control area
  localparam logic [31:0] FORBID_BASE = 32'hFFFFFE00;
  localparam logic [31:0] FORBID_MASK = 32'hFFFFFE00;
  typedef enum logic [1:0] {S_IDLE, S_GNT, S_RD, S_WR} tdc_st_t;
endpackage

// *** logic/tdc_top.sv ***
// Two-channel transfer controller with AXI4-Lite registers and bus master port
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tdc_top (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // AXI4-Lite slave
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Request and acknowledge pins
  input  wire logic        XFER_REQUEST_IN_CH0,
  input  wire logic        XFER_REQUEST_IN_CH1,
  output logic             XFER_ACK_OUT_CH0,
  output logic             XFER_ACK_OUT_CH1,
  input  wire logic        SERIAL_REQ_CH0,
  input  wire logic        SERIAL_REQ_CH1,
  input  wire logic        NMI_IN,
  // External bus master
  output logic             BUS_REQ,
  input  wire logic        BUS_GNT,
  output logic             MEM_VALID,
  input  wire logic        MEM_READY,
  output logic             MEM_WE,
  output logic [31:0]      MEM_ADDR,
  output logic [1:0]       MEM_SIZE,
  output logic [31:0]      MEM_WDATA,
  input  wire logic [31:0] MEM_RDATA,
  // Transfer end requests
  output logic             END_IRQ_CH0,
  output logic             END_IRQ_CH1
);
  import tdc_pkg::*;

  typedef struct packed {
    tdc_st_t          st;
    logic [1:0][31:0] sa;
    logic [1:0][31:0] da;
    logic [1:0][23:0] cnt;
    logic [1:0][15:0] cc;
    logic [1:0][7:0]  rs;
    logic [1:0][6:0]  vec;
    logic [3:0]       op;
    logic [1:0]       te_rd;
    logic [1:0]       fl_rd;
    logic [1:0]       s1;
    logic [1:0]       s2;
    logic [1:0]       sp;
    logic             n1;
    logic             n2;
    logic [1:0]       pend;
    logic             ch;
    logic             rr;
    logic [1:0]       beat;
    logic [3:0][31:0] dbuf;
    logic             breq;
    logic             mvalid;
    logic             mwe;
    logic [31:0]      maddr;
    logic [1:0]       msize;
    logic [31:0]      mwdata;
    logic [1:0]       ackp;
    logic             aw_h;
    logic             w_h;
    logic [31:0]      awa;
    logic [31:0]      wd;
    logic [3:0]       ws;
    logic             bv;
    logic [1:0]       bresp;
    logic             rv;
    logic [31:0]      rd;
    logic [1:0]       rresp;
  } tdc_s_t;

  tdc_s_t      q;
  tdc_s_t      n;
  logic        six;
  logic        sgl;
  logic        fin;
  logic [1:0]  ts;
  logic [23:0] dec;
  logic [23:0] cur_cnt;
  logic [31:0] cur_sa;
  logic [1:0]  ack_act;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ix);
    return a[31:2] == ix[29:0];
  endfunction

  function automatic logic forb(input logic [31:0] a);
    return (a & FORBID_MASK) == FORBID_BASE;
  endfunction

  // Address step by mode and unit size
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m,
                                       input logic [31:0] sz);
    logic [31:0] r;
    r = a;
    if (m == AM_INC) r = a + sz;
    else if (m == AM_DEC) r = a - sz;
    return r;
  endfunction

  // Active channel decode
  assign ts      = q.cc[q.ch][CC_TS+:2];
  assign six     = ts == TS_16;
  assign sgl     = q.cc[q.ch][CC_TA];
  assign dec     = six ? 24'h000004 : 24'h000001;
  assign fin     = q.st == S_WR && q.mvalid && MEM_READY && (!six || q.beat == 2'h3);
  assign cur_cnt = q.cnt[q.ch];
  assign cur_sa  = q.sa[q.ch];

  always_comb begin
    logic [1:0]  lvl;
    logic [1:0]  prv;
    logic [1:0]  req;
    logic [1:0]  rdy;
    logic [1:0]  ser;
    logic        pk;
    logic        ok;
    logic [31:0] sz;
    lvl = 2'h0;
    prv = 2'h0;
    req = 2'h0;
    rdy = 2'h0;
    ser = {SERIAL_REQ_CH1, SERIAL_REQ_CH0};
    pk  = 1'b0;
    ok  = 1'b0;
    sz  = six ? 32'h10 : (32'h1 << ts);
    n   = q;
    // Pin synchronisers; first stage feeds only the second
    n.s1 = {XFER_REQUEST_IN_CH1, XFER_REQUEST_IN_CH0};
    n.s2 = q.s1;
    n.sp = q.s2;
    n.n1 = NMI_IN;
    n.n2 = q.n1;

    // Write channel capture; address and data may come in either order
    if (S_AXI_AWVALID && !q.aw_h) begin
      n.aw_h = 1'b1;
      n.awa  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !q.w_h) begin
      n.w_h = 1'b1;
      n.wd  = S_AXI_WDATA;
      n.ws  = S_AXI_WSTRB;
    end
    if (q.bv && S_AXI_BREADY) n.bv = 1'b0;
    // Register write, one cycle after both halves are held
    if (q.aw_h && q.w_h && !q.bv) begin
      n.aw_h = 1'b0;
      n.w_h  = 1'b0;
      n.bv   = 1'b1;
      for (int c = 0; c < 2; c++) begin
        if (hit(q.awa, IX_SA[c])) begin
          n.sa[c] = q.wd;
          ok = 1'b1;
        end
        if (hit(q.awa, IX_DA[c])) begin
          n.da[c] = q.wd;
          ok = 1'b1;
        end
        if (hit(q.awa, IX_CNT[c])) begin
          n.cnt[c] = q.wd[23:0];
          ok = 1'b1;
        end
        if (hit(q.awa, IX_CC[c])) begin
          n.cc[c] = q.wd[15:0];
          // Flag clears only on a 0 after it was read as 1
          n.cc[c][CC_TE] = q.cc[c][CC_TE] & ~(~q.wd[CC_TE] & q.te_rd[c]);
          n.te_rd[c] = 1'b0;
          ok = 1'b1;
        end
        if (hit(q.awa, IX_VEC[c])) begin
          n.vec[c] = q.wd[6:0];
          ok = 1'b1;
        end
        if (hit(q.awa, IX_RS[c])) begin
          if (q.ws[0]) n.rs[c] = q.wd[7:0];
          ok = 1'b1;
        end
      end
      if (hit(q.awa, IX_OP)) begin
        n.op[OP_DME] = q.wd[OP_DME];
        n.op[OP_PR]  = q.wd[OP_PR];
        n.op[OP_NMIF] = q.op[OP_NMIF] & ~(~q.wd[OP_NMIF] & q.fl_rd[0]);
        n.op[OP_AE]   = q.op[OP_AE] & ~(~q.wd[OP_AE] & q.fl_rd[1]);
        n.fl_rd = 2'h0;
        ok = 1'b1;
      end
      n.bresp = ok ? RESP_OK : RESP_ERR;
    end

    // Register read; reading a set flag arms its clear
    if (q.rv && S_AXI_RREADY) n.rv = 1'b0;
    if (S_AXI_ARVALID && !q.rv) begin
      n.rv    = 1'b1;
      n.rd    = 32'h0;
      n.rresp = RESP_ERR;
      for (int c = 0; c < 2; c++) begin
        if (hit(S_AXI_ARADDR, IX_SA[c])) begin
          n.rd = q.sa[c];
          n.rresp = RESP_OK;
        end
        if (hit(S_AXI_ARADDR, IX_DA[c])) begin
          n.rd = q.da[c];
          n.rresp = RESP_OK;
        end
        if (hit(S_AXI_ARADDR, IX_CNT[c])) begin
          n.rd = {8'h00, q.cnt[c]};
          n.rresp = RESP_OK;
        end
        if (hit(S_AXI_ARADDR, IX_CC[c])) begin
          n.rd = {16'h0000, q.cc[c]};
          n.te_rd[c] = q.cc[c][CC_TE];
          n.rresp = RESP_OK;
        end
        if (hit(S_AXI_ARADDR, IX_VEC[c])) begin
          n.rd = {25'h0, q.vec[c]};
          n.rresp = RESP_OK;
        end
        if (hit(S_AXI_ARADDR, IX_RS[c])) begin
          n.rd = {24'h000000, q.rs[c]};
          n.rresp = RESP_OK;
        end
      end
      if (hit(S_AXI_ARADDR, IX_OP)) begin
        n.rd = {28'h0000000, q.op};
        n.fl_rd = {q.op[OP_AE], q.op[OP_NMIF]};
        n.rresp = RESP_OK;
      end
    end

    // Request detection per channel
    for (int c = 0; c < 2; c++) begin
      lvl[c] = q.s2[c] ^ ~q.cc[c][CC_DL];
      prv[c] = q.sp[c] ^ ~q.cc[c][CC_DL];
      if (q.cc[c][CC_DS] && lvl[c] && !prv[c]) n.pend[c] = 1'b1;
      if (q.cc[c][CC_AR]) req[c] = 1'b1;
      else if (q.rs[c][RS_SER]) req[c] = ser[c];
      else req[c] = q.cc[c][CC_DS] ? q.pend[c] : lvl[c];
      rdy[c] = req[c] & q.cc[c][CC_DE] & ~q.cc[c][CC_TE] & q.op[OP_DME]
             & ~q.op[OP_NMIF] & ~q.op[OP_AE];
    end

    // Transfer engine; only the external bus is borrowed from the processor
    unique case (q.st)
      S_IDLE: begin
        if (|rdy) begin
          pk = (rdy[0] & rdy[1]) ? (q.op[OP_PR] & ~q.rr) : rdy[1];
          if (q.cc[pk][CC_TA] ? forb(q.cc[pk][CC_AM] ? q.sa[pk] : q.da[pk])
                              : (forb(q.sa[pk]) | forb(q.da[pk]))) begin
            n.op[OP_AE] = 1'b1;
          end else begin
            n.ch   = pk;
            n.breq = 1'b1;
            n.st   = S_GNT;
          end
        end
      end
      S_GNT: begin
        if (BUS_GNT) begin
          n.pend[q.ch] = q.cc[q.ch][CC_DS] & lvl[q.ch] & ~prv[q.ch];
          n.beat   = 2'h0;
          n.mvalid = 1'b1;
          n.msize  = six ? TS_LONG : ts;
          if (sgl) begin
            // Device side picked by acknowledge, memory side by address
            n.st    = S_WR;
            n.maddr = q.cc[q.ch][CC_AM] ? q.sa[q.ch] : q.da[q.ch];
            n.mwe   = ~q.cc[q.ch][CC_AM];
          end else begin
            n.st    = S_RD;
            n.maddr = q.sa[q.ch];
            n.mwe   = 1'b0;
          end
        end
      end
      S_RD: begin
        if (q.mvalid && MEM_READY) begin
          n.dbuf[q.beat] = MEM_RDATA;
          if (six && q.beat != 2'h3) begin
            n.beat  = q.beat + 2'h1;
            n.maddr = q.maddr + 32'h4;
          end else begin
            // Write half follows the read half
            n.beat   = 2'h0;
            n.st     = S_WR;
            n.maddr  = q.da[q.ch];
            n.mwe    = 1'b1;
            n.mwdata = six ? q.dbuf[0] : MEM_RDATA;
          end
        end
      end
      S_WR: begin
        if (q.mvalid && MEM_READY && six && q.beat != 2'h3) begin
          n.beat   = q.beat + 2'h1;
          n.maddr  = q.maddr + 32'h4;
          n.mwdata = q.dbuf[q.beat + 2'h1];
        end
      end
    endcase

    // Unit done: pointers and count advance, then end, keep the bus for a burst, or release
    if (fin) begin
      n.mvalid = 1'b0;
      n.mwe    = 1'b0;
      n.rr     = q.ch;
      n.sa[q.ch] = six ? q.sa[q.ch] + 32'h10
                       : step(q.sa[q.ch], q.cc[q.ch][CC_SM+:2], sz);
      n.da[q.ch] = step(q.da[q.ch], q.cc[q.ch][CC_DM+:2], sz);
      // Zero wraps, so a zero count runs the full 2^24 units, or 2^22 sixteen-byte units
      n.cnt[q.ch] = q.cnt[q.ch] - dec;
      if (q.cnt[q.ch] == dec) begin
        n.cc[q.ch][CC_TE] = 1'b1;
        n.breq = 1'b0;
        n.st   = S_IDLE;
      end else if (q.cc[q.ch][CC_TB] && rdy[q.ch]) begin
        n.st = S_GNT;
      end else begin
        n.breq = 1'b0;
        n.st   = S_IDLE;
      end
    end
    // Hardware sets come last so they win over a clear
    if (q.n2) n.op[OP_NMIF] = 1'b1;
    // Acknowledge pin level, polarity from the channel
    for (int c = 0; c < 2; c++) begin
      n.ackp[c] = ~(n.st == S_WR && n.mvalid && n.cc[c][CC_TA] && n.ch == 1'(c))
                ^ n.cc[c][CC_AL];
    end
  end

  // State register
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      q      <= '0;
      q.ackp <= 2'h3;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign S_AXI_AWREADY    = ~q.aw_h;
  assign S_AXI_WREADY     = ~q.w_h;
  assign S_AXI_BVALID     = q.bv;
  assign S_AXI_BRESP      = q.bresp;
  assign S_AXI_ARREADY    = ~q.rv;
  assign S_AXI_RVALID     = q.rv;
  assign S_AXI_RDATA      = q.rd;
  assign S_AXI_RRESP      = q.rresp;
  assign XFER_ACK_OUT_CH0 = q.ackp[0];
  assign XFER_ACK_OUT_CH1 = q.ackp[1];
  assign BUS_REQ          = q.breq;
  assign MEM_VALID        = q.mvalid;
  assign MEM_WE           = q.mwe;
  assign MEM_ADDR         = q.maddr;
  assign MEM_SIZE         = q.msize;
  assign MEM_WDATA        = q.mwdata;
  assign END_IRQ_CH0      = q.cc[0][CC_TE] & q.cc[0][CC_IE];
  assign END_IRQ_CH1      = q.cc[1][CC_TE] & q.cc[1][CC_IE];
  assign ack_act          = q.ackp ~^ {q.cc[1][CC_AL], q.cc[0][CC_AL]};

  // Checks
  default clocking dcb @(posedge MCLK); endclocking
  default disable iff (RESET);

  AST_ONE_ACK: assert property (!(ack_act[0] && ack_act[1]))
    else $error("both acknowledges active");
  AST_16_SPLIT: assert property ((q.st == S_RD && six && q.mvalid && MEM_READY
      && q.beat == 2'h3) |=> (q.st == S_WR && q.beat == 2'h0 && q.mwe))
    else $error("sixteen-byte read half did not turn to writes");
  AST_CNT_DEC: assert property (fin |=> cur_cnt == $past(cur_cnt) - $past(dec))
    else $error("count did not advance by one unit");
  AST_ZERO_MAX: assert property ((fin && cur_cnt == 24'h000000)
      |=> !q.cc[q.ch][CC_TE])
    else $error("zero count ended the run");
  AST_SRC16: assert property ((fin && six) |=> cur_sa == $past(cur_sa) + 32'h10)
    else $error("sixteen-byte source step wrong");
  AST_SGL_NORD: assert property (q.st == S_RD |-> !sgl)
    else $error("read half in single-address mode");
  AST_DUAL_RW: assert property ((q.st == S_WR && $past(q.st) != S_WR && !sgl)
      |-> $past(q.st) == S_RD)
    else $error("dual-address write without read");
  AST_CS_REL: assert property ((fin && !q.cc[q.ch][CC_TB]) |=> !q.breq ##1 q.st != S_RD)
    else $error("cycle-steal kept the bus");
  AST_TE_HW: assert property ($rose(q.cc[0][CC_TE]) |-> $past(fin) && !$past(q.ch))
    else $error("end flag set without unit end");
  AST_AE_STOP: assert property (q.op[OP_AE] |-> ##1 !(q.st == S_GNT && $past(q.st) == S_IDLE))
    else $error("request after address error");
  AST_IRQ: assert property (($rose(q.cc[0][CC_TE]) && q.cc[0][CC_IE]) |-> END_IRQ_CH0)
    else $error("end interrupt missing");
  COV_16: cover property (fin && six && !sgl);
  COV_SGL: cover property (fin && sgl);
  COV_BURST: cover property (fin && q.cc[q.ch][CC_TB] ##1 q.st == S_GNT);
endmodule
`default_nettype wire

// *** testbench/tdc_mem.sv ***
// Memory and bus arbiter beyond the controller's bus master port
`timescale 1ns/1ps
`default_nettype none
module tdc_mem (
  // Clock, reset, stall length
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  slow,
  // Arbitration
  input  wire logic        bus_req,
  output logic             bus_gnt,
  // Access port
  input  wire logic        mem_valid,
  output logic             mem_ready,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rd_ff = 32'h0;
  logic [1:0]  wt_ff = 2'h0;
  // Grant a cycle after the request, withdrawn a cycle after it drops
  always @(posedge clk) bus_gnt <= !rst && bus_req;
  // Ready after a stall; words stored whole, size is the master's concern
  always @(posedge clk) begin
    if (mem_valid && mem_ready && mem_we) mem[mem_addr] = mem_wdata;
    if (rst || !mem_valid || mem_ready) begin
      mem_ready <= 1'h0;
      wt_ff <= 2'h0;
    end else if (wt_ff == slow) begin
      mem_ready <= 1'h1;
      rd_ff <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
    end else begin
      wt_ff <= wt_ff + 2'h1;
    end
  end
  // Off the ready cycle the data lines show the inverse of the last word
  assign mem_rdata = mem_ready ? rd_ff : ~rd_ff;
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the two-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tdc_pkg::*;
  logic        MCLK = 1'h0;
  logic        RESET = 1'h1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, src, dst, cc;
  logic [31:0] pat [4];
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  slow = 2'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h0;
  logic        rready = 1'h0, req0 = 1'h0, ser1 = 1'h0, brq_q = 1'h0;
  logic [15:0] lf = 16'h0041;
  wire logic   awready, wready, bvalid, arready, rvalid, ack0, ack1, breq, bgnt;
  wire logic   mvalid, mready, mwe, irq0, irq1;
  wire logic [1:0]  bresp, rresp, msize;
  wire logic [31:0] rdata, maddr, mwdata, mrdata;
  logic [33:0] rq [$];
  string       rn [$];
  logic [1:0]  bq [$];
  int failures = 0, n_compared = 0, cyc = 0, nacc = 0, nfall = 0, nack = 0;

  tdc_top u_tdc_top (.MCLK(MCLK), .RESET(RESET),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .XFER_REQUEST_IN_CH0(req0), .XFER_REQUEST_IN_CH1(1'h0),
    .XFER_ACK_OUT_CH0(ack0), .XFER_ACK_OUT_CH1(ack1), .SERIAL_REQ_CH0(1'h0),
    .SERIAL_REQ_CH1(ser1), .NMI_IN(1'h0), .BUS_REQ(breq), .BUS_GNT(bgnt),
    .MEM_VALID(mvalid), .MEM_READY(mready), .MEM_WE(mwe), .MEM_ADDR(maddr),
    .MEM_SIZE(msize), .MEM_WDATA(mwdata), .MEM_RDATA(mrdata),
    .END_IRQ_CH0(irq0), .END_IRQ_CH1(irq1));
  tdc_mem u_tdc_mem (.clk(MCLK), .rst(RESET), .slow(slow), .bus_req(breq),
    .bus_gnt(bgnt), .mem_valid(mvalid), .mem_ready(mready), .mem_we(mwe),
    .mem_addr(maddr), .mem_wdata(mwdata), .mem_rdata(mrdata));

  initial forever #12.5 MCLK = ~MCLK;

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Register index to byte address
  function automatic logic [31:0] ba(input logic [31:0] ix);
    return {ix[29:0], 2'h0};
  endfunction
  // Control word: modes and size over the low flag bits
  function automatic logic [31:0] ccv(input logic [1:0] ts, sm, dm, input logic [9:0] b);
    return {16'h0, dm, sm, ts, b};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s response expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] ix, d, input logic [1:0] er = RESP_OK,
                    input logic [3:0] s = 4'hF);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    bq.push_back(er);
    awaddr <= ba(ix);
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge MCLK);
      if (!ad && awready) begin ad = 1'h1; awvalid <= 1'h0; end
      if (!wd && wready) begin wd = 1'h1; wvalid <= 1'h0; end
    end
    do @(posedge MCLK); while (!bvalid);
    bready <= 1'h0;
    @(posedge MCLK);
  endtask
  task automatic rd(input logic [31:0] ix, e, input string nm, input logic [1:0] er = RESP_OK);
    rq.push_back({er, e});
    rn.push_back(nm);
    araddr <= ba(ix);
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge MCLK); while (!arready);
    arvalid <= 1'h0;
    do @(posedge MCLK); while (!rvalid);
    rready <= 1'h0;
    @(posedge MCLK);
  endtask
  task automatic wait_irq(input logic ch);
    for (int i = 0; i < 3000; i++) begin
      @(posedge MCLK);
      if ((ch ? irq1 : irq0) === 1'h1) break;
    end
  endtask
  // Preload n words from the random source; counters zeroed while idle
  task automatic load(input logic [31:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      lf = lfsr(lf);
      pat[i] = {lf, ~lf};
      u_tdc_mem.mem[a + 32'(i * 4)] = pat[i];
    end
    nacc = 0;
    nfall = 0;
    nack = 0;
  endtask

  // Cycle ceiling; running out counts as a mismatch
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      print_verdict;
    end
  end
  // Result watcher: oldest note against each bus answer, plus bus statistics
  always @(posedge MCLK) begin
    if (rvalid && rready) begin
      chk_resp(rn[0], rq[0][33:32], rresp);
      chk(rn[0], rq[0][31:0], rdata);
      void'(rq.pop_front());
      void'(rn.pop_front());
    end
    if (bvalid && bready) chk_resp("write", bq.pop_front(), bresp);
    if (mvalid && mready) begin
      nacc++;
      chk("access size", TS_LONG, msize);
      chk("ack1 idle", 32'h1, ack1);
    end
    if (mvalid && ack0) nack++;
    if (brq_q && !breq) nfall++;
    brq_q <= breq;
  end

  initial begin
    repeat (10) @(posedge MCLK);
    RESET <= 1'h0;
    @(posedge MCLK);
    rd(IX_CC[0], 32'h0, "cc0 reset");
    rd(IX_OP, 32'h0, "op reset");
    rd(IX_RS[0], 32'h0, "rs0 reset");
    rd(32'h100, 32'h0, "unmapped", RESP_ERR);
    wr(32'h100, 32'h5A5A5A5A, RESP_ERR);
    lf = lfsr(lf);
    wr(IX_CNT[0], {8'hA5, 8'h00, lf});
    rd(IX_CNT[0], {16'h0, lf}, "count 24 bits");
    // Dual longword, cycle-steal, auto-request, three units
    src = 32'h1000 + {lf[7:0], 4'h0};
    dst = 32'h9000 + {lf[15:8], 4'h0};
    load(src, 3);
    wr(IX_OP, 32'h1);
    wr(IX_SA[0], src);
    wr(IX_DA[0], dst);
    wr(IX_CNT[0], 32'h3);
    wr(IX_CC[0], ccv(TS_LONG, AM_INC, AM_INC, 10'h205));
    wait_irq(1'h0);
    chk("irq0", 32'h1, irq0);
    rd(IX_SA[0], src + 32'hC, "sa0 next");
    rd(IX_DA[0], dst + 32'hC, "da0 next");
    rd(IX_CNT[0], 32'h0, "count0 left");
    chk("dual accesses", 32'h6, nacc);
    chk("steal releases", 32'h3, nfall);
    for (int i = 0; i < 3; i++) chk("copy", pat[i], u_tdc_mem.mem[dst + 32'(i * 4)]);
    // End flag: write 0 before reading 1 keeps it, write 1 never sets it
    cc = ccv(TS_LONG, AM_INC, AM_INC, 10'h004);
    wr(IX_CC[0], cc);
    rd(IX_CC[0], cc | 32'h2, "flag kept");
    wr(IX_CC[0], cc | 32'h2);
    rd(IX_CC[0], cc | 32'h2, "flag after 1");
    wr(IX_CC[0], cc);
    rd(IX_CC[0], cc, "flag cleared");
    chk("irq0 off", 32'h0, irq0);
    wr(IX_CC[0], cc | 32'h2);
    rd(IX_CC[0], cc, "flag not set");
    // Sixteen-byte unit on ch1 from serial request, slow memory
    src = src + 32'h400;
    dst = dst + 32'h400;
    slow <= 2'h2;
    load(src, 4);
    wr(IX_RS[1], 32'h1, RESP_OK, 4'h1);
    wr(IX_SA[1], src);
    wr(IX_DA[1], dst);
    wr(IX_CNT[1], 32'h4);
    wr(IX_CC[1], ccv(TS_16, AM_DEC, AM_INC, 10'h015));
    ser1 <= 1'h1;
    wait_irq(1'h1);
    ser1 <= 1'h0;
    chk("irq1", 32'h1, irq1);
    rd(IX_SA[1], src + 32'h10, "sa1 plus 16");
    rd(IX_DA[1], dst + 32'h10, "da1 plus 16");
    rd(IX_CNT[1], 32'h0, "count1 left");
    chk("16B accesses", 32'h8, nacc);
    for (int i = 0; i < 4; i++) chk("copy16", pat[i], u_tdc_mem.mem[dst + 32'(i * 4)]);
    // Source in the controller's own area is refused
    load(src, 1);
    wr(IX_SA[0], 32'hFFFFFF00);
    wr(IX_CNT[0], 32'h1);
    wr(IX_CC[0], ccv(TS_LONG, AM_INC, AM_INC, 10'h205));
    repeat (8) @(posedge MCLK);
    rd(IX_OP, 32'h5, "addr error");
    chk("no bus use", 32'h0, nfall);
    wr(IX_CC[0], 32'h0);
    wr(IX_OP, 32'h5);
    rd(IX_OP, 32'h5, "err after 1");
    wr(IX_OP, 32'h1);
    rd(IX_OP, 32'h1, "err cleared");
    // Single-address burst by the pin, level high, acknowledge high
    load(src, 2);
    wr(IX_SA[0], src);
    wr(IX_DA[0], dst);
    wr(IX_CNT[0], 32'h2);
    wr(IX_CC[0], ccv(TS_LONG, AM_INC, AM_INC, 10'h1BD));
    chk("ack idle", 32'h0, ack0);
    req0 <= 1'h1;
    wait_irq(1'h0);
    req0 <= 1'h0;
    rd(IX_CNT[0], 32'h0, "single count");
    chk("single accesses", 32'h2, nacc);
    chk("ack active", 32'h1, 32'(nack >= 2));
    chk("burst release", 32'h1, nfall);
    // Edge request on a zero count: one unit only, count wraps to the maximum
    wr(IX_CNT[0], 32'h0);
    rd(IX_CC[0], ccv(TS_LONG, AM_INC, AM_INC, 10'h1BF), "single end flag");
    wr(IX_CC[0], ccv(TS_LONG, AM_INC, AM_INC, 10'h065));
    load(src, 0);
    req0 <= 1'h1;
    repeat (20) @(posedge MCLK);
    req0 <= 1'h0;
    repeat (4) @(posedge MCLK);
    rd(IX_CNT[0], 32'h00FFFFFF, "zero is max");
    chk("edge accesses", 32'h2, nacc);
    chk("no end irq", 32'h0, irq0);
    print_verdict;
  end
endmodule
`default_nettype wire
